// [common/cbx_defs.svh]
// Constants for the branch, bit and transfer execution core
`ifndef CBX_DEFS_SVH
`define CBX_DEFS_SVH
`define FLG_C 3'h0
`define FLG_Z 3'h1
`define FLG_N 3'h2
`define FLG_V 3'h3
`define FLG_S 3'h4
`define FLG_H 3'h5
`define FLG_T 3'h6
`define FLG_I 3'h7
`define FLAGS_RST 8'h00
`define SP_RST 16'h00FF
`define PTR_X 2'h0
`define PTR_Y 2'h1
`define PTR_X_LO 4'hA
`define PTR_Y_LO 4'hC
`define PTR_Z_LO 4'hE
`define PM_PLAIN 2'h0
`define PM_POST 2'h1
`define PM_PRE 2'h2
`define RA_FLAGS 8'h10
`define RA_PC_LO 8'h11
`define RA_PC_HI 8'h12
`define RA_SP_LO 8'h13
`define RA_SP_HI 8'h14
`define RF_DEPTH 16
`endif

// [common/cbx_pkg.sv]
// Types shared by the branch, bit and transfer execution core
package cbx_pkg;
  typedef enum logic [5:0] {
    OP_BRANCH_SIGNED_LESS, OP_BRANCH_HALF_CARRY_SET,
    OP_BRANCH_HALF_CARRY_CLEAR, OP_BRANCH_TRANSFER_BIT_SET,
    OP_BRANCH_TRANSFER_BIT_CLEAR, OP_BRANCH_OVERFLOW_SET,
    OP_BRANCH_OVERFLOW_CLEAR, OP_BRANCH_IF_IRQ_ON, OP_BRANCH_IF_IRQ_OFF,
    OP_SHIFT_LEFT_LOGICAL, OP_ROTATE_LEFT_CARRY, OP_SHIFT_RIGHT_LOGICAL,
    OP_ROTATE_RIGHT_CARRY, OP_SHIFT_RIGHT_ARITH, OP_NIBBLE_SWAP,
    OP_FLAG_SET, OP_FLAG_CLEAR, OP_IO_BIT_SET, OP_IO_BIT_CLEAR,
    OP_REG_BIT_TO_FLAG, OP_FLAG_TO_REG_BIT, OP_MEMORY_READ_POINTER,
    OP_MEMORY_WRITE_POINTER, OP_MEMORY_READ_DIRECT,
    OP_MEMORY_WRITE_DIRECT, OP_IO_IN, OP_IO_OUT, OP_PUSH, OP_POP,
    OP_BREAK, OP_NOP, OP_SLEEP, OP_WATCHDOG_RESTART
  } cbx_op_t;
  typedef enum logic [1:0] {ST_READY = 2'h1, ST_HOLD = 2'h2} cbx_state_t;
  typedef struct packed {
    cbx_op_t op;
    logic [3:0] rd;
    logic [3:0] rr;
    logic [2:0] bsel;
    logic [7:0] addr;
    logic [6:0] off;
    logic [1:0] ptr;
    logic [1:0] pmode;
  } cbx_issue_t;
  typedef struct packed {
    logic [15:0] addr;
    logic [7:0] wdata;
    logic we;
    logic re;
  } cbx_mem_req_t;
  typedef struct packed {
    logic [5:0] addr;
    logic [7:0] wdata;
    logic we;
    logic re;
    logic bset;
    logic bclr;
    logic [2:0] bsel;
  } cbx_io_req_t;
endpackage : cbx_pkg

// [design/cbx_core.sv]
// Execution core for branch, shift, bit, transfer and control operations
//
// Added by the designer: the address-and-strobe port and the placing of the registers.
`timescale 1ns/1ps
`include "cbx_defs.svh"
// What this block does
// - Signed-less branch jumps by offset plus one when N xor V is one.
// - Half-carry branches jump on H set or clear; flags untouched.
// - Transfer-flag branches jump on T set or clear; 1 or 2 cycles.
// - Overflow branches jump on V set or clear; flags untouched.
// - Interrupt-state branches jump on I set or clear; 1 or 2 cycles.
// - Left shift and rotate-left update Z, C, N, V, H in one cycle.
// - Right shifts and rotate-right update Z, C, N, V in one cycle.
// - Single-flag set or clear changes only that flag, one cycle.
// - I/O bit set or clear touches only the selected bit, one cycle.
// - Bit store copies a bit to T; bit load copies T to a bit.
// - Pointer load reads memory; post-increment bumps pointer, 2 cycles.
// - Pre-decrement load lowers pointer first, then reads there.
// - Pointer store writes in one cycle, post-increment included.
// - Pre-decrement store lowers pointer then writes, two cycles.
// - Direct load and store move a byte at a constant address.
// - I/O in and out move a byte with an I/O location, one cycle.
// - Push and pop move a byte with the stack in two cycles.
// - Break, no-op, sleep and watchdog restart issue in one cycle.
module cbx_core
  import cbx_pkg::*;
#(
  parameter int PC_W = 16,
  parameter logic [15:0] SP_INIT = `SP_RST
) (
  input wire logic core_clk,
  input wire logic arst_n,
  input wire logic issue_valid,
  input wire cbx_issue_t issue,
  output logic issue_ready,
  output logic [PC_W-1:0] pc,
  output logic [7:0] flags,
  output cbx_mem_req_t mem_req,
  input wire logic [7:0] mem_rdata,
  output cbx_io_req_t io_req,
  input wire logic [7:0] io_rdata,
  output logic break_pulse,
  output logic sleep_pulse,
  output logic wdog_restart_pulse,
  input wire logic [7:0] reg_addr,
  input wire logic [7:0] reg_wdata,
  input wire logic reg_we,
  input wire logic reg_re,
  output logic [7:0] reg_rdata
);
  logic [7:0] regs_ff [`RF_DEPTH];
  logic [7:0] flags_ff;
  logic [PC_W-1:0] pc_ff;
  logic [15:0] sp_ff;
  cbx_state_t state_ff;
  logic issue_ready_ff;
  cbx_mem_req_t mem_req_ff;
  cbx_io_req_t io_req_ff;
  logic break_ff;
  logic sleep_ff;
  logic wdog_ff;
  logic [7:0] reg_rdata_ff;
  logic wb1_ff;
  logic wb2_ff;
  logic wb_io1_ff;
  logic wb_io2_ff;
  logic [3:0] wb_idx1_ff;
  logic [3:0] wb_idx2_ff;
  logic go;
  logic taken;
  logic is_branch;
  logic [7:0] wb_data;
  logic [7:0] opd;
  logic [7:0] ops;
  logic [3:0] ptr_lo;
  logic [15:0] ptr_v;
  logic [PC_W-1:0] br_tgt;
  logic [7:0] nxt_res;
  logic nxt_res_we;
  logic [7:0] nxt_flags;
  logic [PC_W-1:0] nxt_pc;
  logic [15:0] nxt_ptr;
  logic nxt_ptr_we;
  logic [15:0] nxt_sp;
  cbx_mem_req_t nxt_mem;
  cbx_io_req_t nxt_io;
  logic nxt_wb;
  logic nxt_wb_io;
  logic nxt_hold;
  logic nxt_break;
  logic nxt_sleep;
  logic nxt_wdog;
  logic sh_upd;
  logic sh_left;
  logic sh_c;

  assign issue_ready = issue_ready_ff;
  assign pc = pc_ff;
  assign flags = flags_ff;
  assign mem_req = mem_req_ff;
  assign io_req = io_req_ff;
  assign break_pulse = break_ff;
  assign sleep_pulse = sleep_ff;
  assign wdog_restart_pulse = wdog_ff;
  assign reg_rdata = reg_rdata_ff;

  assign go = issue_valid && issue_ready_ff;
  assign is_branch = issue.op <= OP_BRANCH_IF_IRQ_OFF;
  assign wb_data = wb_io2_ff ? io_rdata : mem_rdata;

  // Returning load data is forwarded so the op issued two cycles later
  // sees it; the op issued right after a load cannot.
  function automatic logic [7:0] rd_reg(input logic [3:0] i);
    rd_reg = (wb2_ff && wb_idx2_ff == i) ? wb_data : regs_ff[i];
  endfunction : rd_reg

  assign ptr_lo = (issue.ptr == `PTR_X) ? `PTR_X_LO :
                  (issue.ptr == `PTR_Y) ? `PTR_Y_LO : `PTR_Z_LO;

  // A process, not assigns, so register file changes re-trigger the reads
  always_comb begin
    opd = rd_reg(issue.rd);
    ops = rd_reg(issue.rr);
    ptr_v = {rd_reg(ptr_lo + 4'h1), rd_reg(ptr_lo)};
  end
  assign br_tgt = pc_ff + PC_W'(1) +
                  {{(PC_W-7){issue.off[6]}}, issue.off};

  always_comb begin
    unique case (issue.op)
      OP_BRANCH_SIGNED_LESS:
        taken = flags_ff[`FLG_N] ^ flags_ff[`FLG_V];
      OP_BRANCH_HALF_CARRY_SET: taken = flags_ff[`FLG_H];
      OP_BRANCH_HALF_CARRY_CLEAR: taken = !flags_ff[`FLG_H];
      OP_BRANCH_TRANSFER_BIT_SET: taken = flags_ff[`FLG_T];
      OP_BRANCH_TRANSFER_BIT_CLEAR: taken = !flags_ff[`FLG_T];
      OP_BRANCH_OVERFLOW_SET: taken = flags_ff[`FLG_V];
      OP_BRANCH_OVERFLOW_CLEAR: taken = !flags_ff[`FLG_V];
      OP_BRANCH_IF_IRQ_ON: taken = flags_ff[`FLG_I];
      OP_BRANCH_IF_IRQ_OFF: taken = !flags_ff[`FLG_I];
      default: taken = 1'b0;
    endcase
  end

  always_comb begin
    nxt_pc = pc_ff;
    nxt_res = opd;
    nxt_res_we = 1'b0;
    nxt_flags = flags_ff;
    nxt_ptr = ptr_v;
    nxt_ptr_we = 1'b0;
    nxt_sp = sp_ff;
    nxt_mem = '0;
    nxt_io = '0;
    nxt_wb = 1'b0;
    nxt_wb_io = 1'b0;
    nxt_hold = 1'b0;
    nxt_break = 1'b0;
    nxt_sleep = 1'b0;
    nxt_wdog = 1'b0;
    sh_upd = 1'b0;
    sh_left = 1'b0;
    sh_c = 1'b0;
    if (go) begin
      nxt_pc = pc_ff + PC_W'(1);
      if (is_branch && taken) begin
        nxt_pc = br_tgt;
        nxt_hold = 1'b1;
      end
      unique case (issue.op)
        OP_SHIFT_LEFT_LOGICAL: begin
          nxt_res = {opd[6:0], 1'b0};
          sh_left = 1'b1;
        end
        OP_ROTATE_LEFT_CARRY: begin
          nxt_res = {opd[6:0], flags_ff[`FLG_C]};
          sh_left = 1'b1;
        end
        OP_SHIFT_RIGHT_LOGICAL: nxt_res = {1'b0, opd[7:1]};
        OP_ROTATE_RIGHT_CARRY:
          nxt_res = {flags_ff[`FLG_C], opd[7:1]};
        OP_SHIFT_RIGHT_ARITH: nxt_res = {opd[7], opd[7:1]};
        OP_NIBBLE_SWAP: begin
          nxt_res = {opd[3:0], opd[7:4]};
          nxt_res_we = 1'b1;
        end
        OP_FLAG_SET: nxt_flags[issue.bsel] = 1'b1;
        OP_FLAG_CLEAR: nxt_flags[issue.bsel] = 1'b0;
        OP_IO_BIT_SET, OP_IO_BIT_CLEAR: begin
          nxt_io.addr = issue.addr[5:0];
          nxt_io.bsel = issue.bsel;
          nxt_io.bset = issue.op == OP_IO_BIT_SET;
          nxt_io.bclr = issue.op == OP_IO_BIT_CLEAR;
        end
        OP_REG_BIT_TO_FLAG: nxt_flags[`FLG_T] = opd[issue.bsel];
        OP_FLAG_TO_REG_BIT: begin
          nxt_res[issue.bsel] = flags_ff[`FLG_T];
          nxt_res_we = 1'b1;
        end
        OP_MEMORY_READ_POINTER: begin
          nxt_mem.re = 1'b1;
          nxt_mem.addr = ptr_v;
          nxt_wb = 1'b1;
          if (issue.pmode == `PM_POST) begin
            nxt_ptr = ptr_v + 16'h0001;
            nxt_ptr_we = 1'b1;
            nxt_hold = 1'b1;
          end else if (issue.pmode == `PM_PRE) begin
            nxt_ptr = ptr_v - 16'h0001;
            nxt_mem.addr = nxt_ptr;
            nxt_ptr_we = 1'b1;
            nxt_hold = 1'b1;
          end
        end
        OP_MEMORY_WRITE_POINTER: begin
          nxt_mem.we = 1'b1;
          nxt_mem.addr = ptr_v;
          nxt_mem.wdata = ops;
          if (issue.pmode == `PM_POST) begin
            nxt_ptr = ptr_v + 16'h0001;
            nxt_ptr_we = 1'b1;
          end else if (issue.pmode == `PM_PRE) begin
            nxt_ptr = ptr_v - 16'h0001;
            nxt_mem.addr = nxt_ptr;
            nxt_ptr_we = 1'b1;
            nxt_hold = 1'b1;
          end
        end
        OP_MEMORY_READ_DIRECT: begin
          nxt_mem.re = 1'b1;
          nxt_mem.addr = {8'h00, issue.addr};
          nxt_wb = 1'b1;
        end
        OP_MEMORY_WRITE_DIRECT: begin
          nxt_mem.we = 1'b1;
          nxt_mem.addr = {8'h00, issue.addr};
          nxt_mem.wdata = ops;
        end
        OP_IO_IN: begin
          nxt_io.re = 1'b1;
          nxt_io.addr = issue.addr[5:0];
          nxt_wb = 1'b1;
          nxt_wb_io = 1'b1;
        end
        OP_IO_OUT: begin
          nxt_io.we = 1'b1;
          nxt_io.addr = issue.addr[5:0];
          nxt_io.wdata = ops;
        end
        OP_PUSH: begin
          nxt_mem.we = 1'b1;
          nxt_mem.addr = sp_ff;
          nxt_mem.wdata = ops;
          nxt_sp = sp_ff - 16'h0001;
          nxt_hold = 1'b1;
        end
        OP_POP: begin
          nxt_sp = sp_ff + 16'h0001;
          nxt_mem.re = 1'b1;
          nxt_mem.addr = nxt_sp;
          nxt_wb = 1'b1;
          nxt_hold = 1'b1;
        end
        OP_BREAK: nxt_break = 1'b1;
        OP_SLEEP: nxt_sleep = 1'b1;
        OP_WATCHDOG_RESTART: nxt_wdog = 1'b1;
        default: nxt_res = opd;
      endcase
      if (issue.op >= OP_SHIFT_LEFT_LOGICAL &&
          issue.op <= OP_SHIFT_RIGHT_ARITH) begin
        sh_upd = 1'b1;
        nxt_res_we = 1'b1;
      end
      if (sh_upd) begin
        sh_c = sh_left ? opd[7] : opd[0];
        nxt_flags[`FLG_C] = sh_c;
        nxt_flags[`FLG_Z] = nxt_res == 8'h00;
        nxt_flags[`FLG_N] = nxt_res[7];
        nxt_flags[`FLG_V] = nxt_res[7] ^ sh_c;
        if (sh_left) begin
          nxt_flags[`FLG_H] = opd[3];
        end
      end
    end
  end

  // One idle slot after every two-cycle operation
  always_ff @(posedge core_clk or negedge arst_n) begin
    if (!arst_n) begin
      state_ff <= ST_READY;
      issue_ready_ff <= 1'b1;
    end else begin
      unique case (state_ff)
        ST_READY: begin
          if (go && nxt_hold) begin
            state_ff <= ST_HOLD;
            issue_ready_ff <= 1'b0;
          end
        end
        ST_HOLD: begin
          state_ff <= ST_READY;
          issue_ready_ff <= 1'b1;
        end
        default: begin
          state_ff <= ST_READY;
          issue_ready_ff <= 1'b1;
        end
      endcase
    end
  end

  always_ff @(posedge core_clk or negedge arst_n) begin
    if (!arst_n) begin
      pc_ff <= '0;
      sp_ff <= SP_INIT;
    end else begin
      pc_ff <= nxt_pc;
      sp_ff <= nxt_sp;
    end
  end

  // Any issued op wins over a same-cycle host flag write, even one that leaves the flags alone
  always_ff @(posedge core_clk or negedge arst_n) begin
    if (!arst_n) begin
      flags_ff <= `FLAGS_RST;
    end else if (reg_we && reg_addr == `RA_FLAGS && !go) begin
      flags_ff <= reg_wdata;
    end else begin
      flags_ff <= nxt_flags;
    end
  end

  always_ff @(posedge core_clk or negedge arst_n) begin
    if (!arst_n) begin
      mem_req_ff <= '0;
      io_req_ff <= '0;
      break_ff <= 1'b0;
      sleep_ff <= 1'b0;
      wdog_ff <= 1'b0;
    end else begin
      mem_req_ff <= nxt_mem;
      io_req_ff <= nxt_io;
      break_ff <= nxt_break;
      sleep_ff <= nxt_sleep;
      wdog_ff <= nxt_wdog;
    end
  end

  // Read data arrives one cycle after the request, two after issue
  always_ff @(posedge core_clk or negedge arst_n) begin
    if (!arst_n) begin
      wb1_ff <= 1'b0;
      wb2_ff <= 1'b0;
      wb_io1_ff <= 1'b0;
      wb_io2_ff <= 1'b0;
      wb_idx1_ff <= 4'h0;
      wb_idx2_ff <= 4'h0;
    end else begin
      wb1_ff <= nxt_wb;
      wb2_ff <= wb1_ff;
      wb_io1_ff <= nxt_wb_io;
      wb_io2_ff <= wb_io1_ff;
      wb_idx1_ff <= issue.rd;
      wb_idx2_ff <= wb_idx1_ff;
    end
  end

  // Later writes win: host, then load return, then result, then pointer
  always_ff @(posedge core_clk or negedge arst_n) begin
    if (!arst_n) begin
      for (int i = 0; i < `RF_DEPTH; i++) begin
        regs_ff[i] <= 8'h00;
      end
    end else begin
      if (reg_we && reg_addr < 8'(`RF_DEPTH)) begin
        regs_ff[reg_addr[3:0]] <= reg_wdata;
      end
      if (wb2_ff) begin
        regs_ff[wb_idx2_ff] <= wb_data;
      end
      if (nxt_res_we) begin
        regs_ff[issue.rd] <= nxt_res;
      end
      if (nxt_ptr_we) begin
        regs_ff[ptr_lo] <= nxt_ptr[7:0];
        regs_ff[ptr_lo + 4'h1] <= nxt_ptr[15:8];
      end
    end
  end

  always_ff @(posedge core_clk or negedge arst_n) begin
    if (!arst_n) begin
      reg_rdata_ff <= 8'h00;
    end else if (reg_re) begin
      if (reg_addr < 8'(`RF_DEPTH)) begin
        reg_rdata_ff <= regs_ff[reg_addr[3:0]];
      end else begin
        unique case (reg_addr)
          `RA_FLAGS: reg_rdata_ff <= flags_ff;
          `RA_PC_LO: reg_rdata_ff <= 8'(pc_ff);
          `RA_PC_HI: reg_rdata_ff <= 8'(16'(pc_ff) >> 8);
          `RA_SP_LO: reg_rdata_ff <= sp_ff[7:0];
          `RA_SP_HI: reg_rdata_ff <= sp_ff[15:8];
          default: reg_rdata_ff <= 8'h00;
        endcase
      end
    end else begin
      reg_rdata_ff <= 8'h00;
    end
  end

  default clocking cb @(posedge core_clk);
  endclocking
  default disable iff (!arst_n);

  sequence s_hold_one;
    !issue_ready_ff ##1 issue_ready_ff;
  endsequence
  sequence s_go(cbx_op_t o);
    go && issue.op == o;
  endsequence

  AST_SLT_TAKEN: assert property (
    s_go(OP_BRANCH_SIGNED_LESS) ##0 taken |=>
      pc_ff == $past(br_tgt) ##0 s_hold_one)
    else $error("signed-less branch target or timing wrong");
  AST_HC_FLAGS: assert property (
    go && (issue.op == OP_BRANCH_HALF_CARRY_SET ||
           issue.op == OP_BRANCH_HALF_CARRY_CLEAR) |=>
      flags_ff == $past(flags_ff))
    else $error("half-carry branch changed flags");
  AST_T_NOT_TAKEN: assert property (
    s_go(OP_BRANCH_TRANSFER_BIT_CLEAR) ##0 flags_ff[`FLG_T] |=>
      issue_ready_ff && pc_ff == $past(pc_ff) + PC_W'(1))
    else $error("untaken transfer branch not one cycle");
  AST_OVF_TAKEN: assert property (
    s_go(OP_BRANCH_OVERFLOW_SET) ##0 flags_ff[`FLG_V] |=>
      pc_ff == $past(br_tgt))
    else $error("overflow branch missed its target");
  AST_IRQ_OFF_TAKEN: assert property (
    s_go(OP_BRANCH_IF_IRQ_OFF) ##0 !flags_ff[`FLG_I] |=> s_hold_one)
    else $error("taken interrupt-state branch not two cycles");
  AST_SHL_FLAGS: assert property (
    s_go(OP_SHIFT_LEFT_LOGICAL) |=>
      flags_ff[`FLG_C] == $past(opd[7]) &&
      flags_ff[`FLG_H] == $past(opd[3]) && issue_ready_ff)
    else $error("left shift flags wrong");
  AST_ASR_KEEP: assert property (
    s_go(OP_SHIFT_RIGHT_ARITH) |=>
      flags_ff[`FLG_C] == $past(opd[0]) &&
      flags_ff[`FLG_S] == $past(flags_ff[`FLG_S]))
    else $error("arithmetic right shift flags wrong");
  AST_FLAG_SET: assert property (
    s_go(OP_FLAG_SET) |=> flags_ff[$past(issue.bsel)] &&
      ((flags_ff ^ $past(flags_ff)) & ~(8'h01 << $past(issue.bsel)))
        == 8'h00)
    else $error("flag set touched other flags");
  AST_IO_BIT: assert property (
    s_go(OP_IO_BIT_CLEAR) |=> io_req_ff.bclr && !io_req_ff.we &&
      io_req_ff.bsel == $past(issue.bsel))
    else $error("I/O bit clear request wrong");
  AST_LD_DIRECT: assert property (
    s_go(OP_MEMORY_READ_DIRECT) |=> mem_req_ff.re && issue_ready_ff
      ##2 regs_ff[$past(issue.rd, 3)] == $past(mem_rdata))
    else $error("direct load did not return data");
  AST_PREDEC_ST: assert property (
    s_go(OP_MEMORY_WRITE_POINTER) ##0 issue.pmode == `PM_PRE |=>
      mem_req_ff.we && mem_req_ff.addr == $past(ptr_v) - 16'h0001
      ##0 s_hold_one)
    else $error("pre-decrement store wrong");
  AST_PUSH: assert property (
    s_go(OP_PUSH) |=> mem_req_ff.we &&
      mem_req_ff.addr == $past(sp_ff) &&
      sp_ff == $past(sp_ff) - 16'h0001 ##0 s_hold_one)
    else $error("push wrong");
endmodule : cbx_core

// [tb/cbx_far_model.sv]
// Data memory and I/O space model facing the execution core
`timescale 1ns/1ps
module cbx_far_model
  import cbx_pkg::*;
(
  input wire logic core_clk,
  input wire cbx_mem_req_t mem_req,
  output logic [7:0] mem_rdata,
  input wire cbx_io_req_t io_req,
  output logic [7:0] io_rdata
);
  logic [7:0] mem_ff [256];
  logic [7:0] io_ff [64];
  initial begin
    mem_rdata = 8'h5A;
    io_rdata = 8'hA5;
    foreach (mem_ff[i]) mem_ff[i] = 8'h00;
    foreach (io_ff[i]) io_ff[i] = 8'h00;
  end
  // Read data is only good the cycle after a read; it churns otherwise
  // so that a late or missing strobe cannot pick up a stale answer
  always @(posedge core_clk) begin
    mem_rdata <= mem_req.re ? mem_ff[mem_req.addr[7:0]] : ~mem_rdata;
    io_rdata <= io_req.re ? io_ff[io_req.addr] : ~io_rdata;
    if (mem_req.we) mem_ff[mem_req.addr[7:0]] <= mem_req.wdata;
    if (io_req.we) io_ff[io_req.addr] <= io_req.wdata;
    if (io_req.bset) io_ff[io_req.addr][io_req.bsel] <= 1'b1;
    if (io_req.bclr) io_ff[io_req.addr][io_req.bsel] <= 1'b0;
  end
endmodule : cbx_far_model

// [tb/cbx_core_bench.sv]
// Self-checking bench for the execution core and its far-side model
`timescale 1ns/1ps
`include "cbx_defs.svh"
module cbx_core_bench
  import cbx_pkg::*;
;
  localparam logic [15:0] SP0 = `SP_RST;
  logic core_clk = 1'b0;
  logic arst_n = 1'b0;
  logic issue_valid = 1'b0;
  cbx_issue_t issue = '0;
  logic issue_ready;
  logic [15:0] pc;
  logic [7:0] flags, mem_rdata, io_rdata, reg_rdata;
  cbx_mem_req_t mem_req, gm;
  cbx_io_req_t io_req, gi;
  logic break_pulse, sleep_pulse, wdog_restart_pulse;
  logic [7:0] reg_addr = 8'h00;
  logic [7:0] reg_wdata = 8'h00;
  logic reg_we = 1'b0;
  logic reg_re = 1'b0;
  logic re_d = 1'b0;
  int n_mismatch = 0;
  int samples_checked = 0;
  logic [31:0] rnd = 32'h0000_9E50;
  logic [7:0] ef = `FLAGS_RST;
  logic [15:0] epc = 16'h0000;
  logic [7:0] d, q, r, v0, v1, v2, lo;
  logic [6:0] o;
  logic [15:0] b16;
  logic [5:0] a6;
  logic [2:0] b;
  logic [1:0] pp;
  logic t, c;
  logic [8:0] rq[$];
  cbx_mem_req_t mq[$];
  cbx_io_req_t iq[$];

  cbx_core i_cbx_core (.core_clk, .arst_n, .issue_valid, .issue,
    .issue_ready, .pc, .flags, .mem_req, .mem_rdata, .io_req, .io_rdata,
    .break_pulse, .sleep_pulse, .wdog_restart_pulse, .reg_addr,
    .reg_wdata, .reg_we, .reg_re, .reg_rdata);
  cbx_far_model i_cbx_far_model (.core_clk, .mem_req, .mem_rdata,
    .io_req, .io_rdata);

  always #50 core_clk = ~core_clk;

  function automatic logic [7:0] rnd8();
    rnd ^= rnd << 13;
    rnd ^= rnd >> 17;
    rnd ^= rnd << 5;
    return rnd[7:0];
  endfunction : rnd8

  function automatic cbx_issue_t mk(cbx_op_t op, logic [3:0] rg = 4'h0,
    logic [2:0] bs = 3'h0, logic [7:0] a = 8'h00, logic [6:0] f = 7'h00,
    logic [1:0] p = 2'h0, logic [1:0] m = 2'h0);
    return '{op, rg, rg, bs, a, f, p, m};
  endfunction : mk

  function automatic logic taken(int k, logic [7:0] f);
    case (k)
      0: return f[`FLG_N] ^ f[`FLG_V];
      1: return f[`FLG_H];
      2: return !f[`FLG_H];
      3: return f[`FLG_T];
      4: return !f[`FLG_T];
      5: return f[`FLG_V];
      6: return !f[`FLG_V];
      7: return f[`FLG_I];
      default: return !f[`FLG_I];
    endcase
  endfunction : taken

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    samples_checked++;
    if (got !== exp) begin
      n_mismatch++;
      $display("[ERR] t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask : chk

  task automatic give_verdict();
    $display("checks=%0d mismatches=%0d", samples_checked, n_mismatch);
    if (n_mismatch == 0 && samples_checked > 0)
      $display("SIMULATION PASSED");
    else
      $display("SIMULATION FAILED");
    $finish;
  endtask : give_verdict

  task automatic host_wr(input logic [7:0] a, input logic [7:0] v);
    reg_re <= 1'b0;
    reg_we <= 1'b1;
    reg_addr <= a;
    reg_wdata <= v;
    @(posedge core_clk);
  endtask : host_wr

  task automatic host_rd(input logic [7:0] a, input logic [7:0] e);
    reg_we <= 1'b0;
    reg_re <= 1'b1;
    reg_addr <= a;
    rq.push_back({1'b0, e});
    @(posedge core_clk);
  endtask : host_rd

  task automatic nm(input logic [15:0] a, input logic [7:0] v, input w);
    mq.push_back({a, w ? v : 8'h00, w, !w});
  endtask : nm

  // Offer one op, hold it until taken, then check timing, pc and flags
  task automatic run(cbx_issue_t op, logic two = 1'b0,
    logic [2:0] pl = 3'h0);
    int n;
    n = 0;
    reg_we <= 1'b0;
    reg_re <= 1'b0;
    issue_valid <= 1'b1;
    issue <= op;
    do begin
      @(posedge core_clk);
      n++;
    end while (!issue_ready && n < 8);
    if (n == 8) begin
      n_mismatch++;
      give_verdict();
    end
    issue_valid <= 1'b0;
    epc = epc + 16'h0001;
    @(posedge core_clk);
    chk(issue_ready, !two);
    chk({break_pulse, sleep_pulse, wdog_restart_pulse}, pl);
    @(posedge core_clk);
    chk(pc, epc);
    chk(flags, ef);
  endtask : run

  task automatic mop(cbx_op_t op, logic [3:0] rg, logic [1:0] m, logic tw);
    run(mk(op, rg, 3'h0, 8'h00, 7'h00, pp, m), tw);
  endtask : mop

  // Results are compared when they appear, against the oldest note
  always @(posedge core_clk) begin
    if (re_d) chk(reg_rdata, rq.size() ? rq.pop_front() : 9'h100);
    re_d = reg_re;
    if (mem_req.we | mem_req.re) begin
      gm = mem_req;
      if (!gm.we) gm.wdata = 8'h00;
      chk(gm, mq.size() ? mq.pop_front() : '1);
    end
    if (io_req.we | io_req.re | io_req.bset | io_req.bclr) begin
      gi = io_req;
      if (!gi.we) gi.wdata = 8'h00;
      if (!(gi.bset | gi.bclr)) gi.bsel = 3'h0;
      chk(gi, iq.size() ? iq.pop_front() : '1);
    end
  end

  initial begin
    #6_000_000;
    n_mismatch++;
    give_verdict();
  end

  initial begin
    repeat (2) @(posedge core_clk);
    arst_n <= 1'b1;
    host_rd(`RA_FLAGS, `FLAGS_RST);
    host_rd(`RA_SP_LO, SP0[7:0]);
    host_rd(`RA_SP_HI, SP0[15:8]);
    host_rd(8'h3F, 8'h00);
    $display("end of reset test");
    for (int s = 0; s < 8; s++) begin
      ef = rnd8();
      host_wr(`RA_FLAGS, ef);
      ef[s] = 1'b1;
      run(mk(OP_FLAG_SET, 4'h0, 3'(s)));
      ef[s] = 1'b0;
      run(mk(OP_FLAG_CLEAR, 4'h0, 3'(s)));
    end
    $display("end of flag test");
    for (int k = 0; k < 9; k++) begin
      r = rnd8();
      for (int j = 0; j < 2; j++) begin
        ef = j ? r ^ 8'hE8 : r;
        o = (k == 0) ? 7'h40 : (k == 1) ? 7'h3F : 7'(rnd8());
        host_wr(`RA_FLAGS, ef);
        t = taken(k, ef);
        if (t) epc = epc + {{9{o[6]}}, o};
        run(mk(cbx_op_t'(6'(k)), .f(o)), t);
      end
    end
    $display("end of branch test");
    for (int k = 9; k < 15; k++) begin
      d = rnd8();
      ef = rnd8();
      host_wr(8'h01, d);
      host_wr(`RA_FLAGS, ef);
      c = ef[`FLG_C];
      case (k)
        9: {c, q} = {d, 1'b0};
        10: {c, q} = {d, c};
        11: {q, c} = {1'b0, d};
        12: {q, c} = {c, d};
        13: {q, c} = {d[7], d};
        default: q = {d[3:0], d[7:4]};
      endcase
      if (k < 14) begin
        ef[`FLG_C] = c;
        ef[`FLG_Z] = (q == 8'h00);
        ef[`FLG_N] = q[7];
        ef[`FLG_V] = q[7] ^ c;
        if (k < 11) ef[`FLG_H] = d[3];
      end
      run(mk(cbx_op_t'(6'(k)), 4'h1));
      host_rd(8'h01, q);
    end
    $display("end of shift test");
    for (int i = 0; i < 4; i++) begin
      d = rnd8();
      q = rnd8();
      b = 3'(rnd8());
      host_wr(8'h02, d);
      host_wr(8'h03, q);
      ef[`FLG_T] = d[b];
      run(mk(OP_REG_BIT_TO_FLAG, 4'h2, b));
      b = 3'(rnd8());
      q[b] = ef[`FLG_T];
      run(mk(OP_FLAG_TO_REG_BIT, 4'h3, b));
      host_rd(8'h03, q);
    end
    $display("end of bit transfer test");
    a6 = 6'(rnd8());
    d = rnd8();
    host_wr(8'h04, d);
    iq.push_back({a6, d, 4'h8, 3'h0});
    run(mk(OP_IO_OUT, 4'h4, .a({2'h0, a6})));
    for (int i = 0; i < 4; i++) begin
      b = 3'(rnd8());
      iq.push_back({a6, 8'h00, 2'h0, !i[0], i[0], b});
      d[b] = !i[0];
      run(mk(i[0] ? OP_IO_BIT_CLEAR : OP_IO_BIT_SET, 4'h0, b,
        {2'h0, a6}));
    end
    iq.push_back({a6, 8'h00, 4'h4, 3'h0});
    run(mk(OP_IO_IN, 4'h5, .a({2'h0, a6})));
    host_rd(8'h05, d);
    $display("end of io test");
    for (int p = 0; p < 3; p++) begin
      // Last pointer starts at a page edge so the carry reaches the hi byte
      pp = 2'(p);
      b16 = (p == 2) ? 16'h01FF : 16'h0040 + 16'(p * 16);
      lo = 8'h0A + 8'(p * 2);
      v0 = rnd8();
      v1 = rnd8();
      v2 = rnd8();
      host_wr(lo, b16[7:0]);
      host_wr(lo + 8'h01, b16[15:8]);
      host_wr(8'h00, v0);
      host_wr(8'h01, v1);
      host_wr(8'h02, v2);
      nm(b16, v0, 1'b1);
      mop(OP_MEMORY_WRITE_POINTER, 4'h0, `PM_POST, 1'b0);
      nm(b16 + 16'h0001, v1, 1'b1);
      mop(OP_MEMORY_WRITE_POINTER, 4'h1, `PM_PLAIN, 1'b0);
      nm(b16, v2, 1'b1);
      mop(OP_MEMORY_WRITE_POINTER, 4'h2, `PM_PRE, 1'b1);
      nm(b16, 8'h00, 1'b0);
      mop(OP_MEMORY_READ_POINTER, 4'h3, `PM_POST, 1'b1);
      nm(b16 + 16'h0001, 8'h00, 1'b0);
      mop(OP_MEMORY_READ_POINTER, 4'h4, `PM_PLAIN, 1'b0);
      nm(b16, 8'h00, 1'b0);
      mop(OP_MEMORY_READ_POINTER, 4'h5, `PM_PRE, 1'b1);
      host_rd(8'h03, v2);
      host_rd(8'h04, v1);
      host_rd(8'h05, v2);
      host_rd(lo, b16[7:0]);
      host_rd(lo + 8'h01, b16[15:8]);
    end
    $display("end of pointer test");
    r = rnd8();
    d = rnd8();
    host_wr(8'h06, d);
    nm({8'h00, r}, d, 1'b1);
    run(mk(OP_MEMORY_WRITE_DIRECT, 4'h6, .a(r)));
    nm({8'h00, r}, 8'h00, 1'b0);
    run(mk(OP_MEMORY_READ_DIRECT, 4'h7, .a(r)));
    host_rd(8'h07, d);
    $display("end of direct test");
    v0 = rnd8();
    v1 = rnd8();
    host_wr(8'h08, v0);
    host_wr(8'h09, v1);
    nm(SP0, v0, 1'b1);
    run(mk(OP_PUSH, 4'h8), 1'b1);
    nm(SP0 - 16'h0001, v1, 1'b1);
    run(mk(OP_PUSH, 4'h9), 1'b1);
    host_rd(`RA_SP_LO, 8'(SP0 - 16'h0002));
    nm(SP0 - 16'h0001, 8'h00, 1'b0);
    run(mk(OP_POP, 4'h0), 1'b1);
    nm(SP0, 8'h00, 1'b0);
    run(mk(OP_POP, 4'h1), 1'b1);
    host_rd(8'h00, v1);
    host_rd(8'h01, v0);
    host_rd(`RA_SP_LO, SP0[7:0]);
    $display("end of stack test");
    for (int k = 29; k < 33; k++) begin
      b = (k == 29) ? 3'h4 : (k == 31) ? 3'h2 : {2'h0, k == 32};
      run(mk(cbx_op_t'(6'(k))), 1'b0, b);
    end
    $display("end of control test");
    host_rd(8'h3F, 8'h00);
    reg_re <= 1'b0;
    repeat (3) @(posedge core_clk);
    chk(rq.size() + mq.size() + iq.size(), 0);
    give_verdict();
  end
endmodule : cbx_core_bench
